//--- verilog/fsru_top.v
// Purpose: Two-byte status register of a serial flash, SPI mode 0/3
// Assumes: Serial pins asynchronous, oversampled by clk_i (8x or more)
// Notes: Program/erase engine and main opcode decoder sit outside
`timescale 1ns/1ps
`default_nettype none
`include "fsru_map.vh"

module fsru_top (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // Serial pins
  input wire cs_n_i,
  input wire sclk_i,
  input wire si_i,
  input wire wp_n_i,
  output reg so_o,
  output reg so_oe_o,
  // Device core side
  input wire op_busy_i,
  input wire op_done_i,
  input wire op_fail_i,
  input wire wel_set_i,
  input wire wel_clr_i,
  input wire soft_rst_req_i,
  // Protection state out
  output reg protect_lock_o,
  output reg array_protect_o,
  output reg write_enable_latch_o,
  output reg prog_permit_o,
  output reg soft_reset_o
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_CMD = 6'h02;
  localparam [5:0] ST_READ = 6'h04;
  localparam [5:0] ST_WSR1 = 6'h08;
  localparam [5:0] ST_WSR2 = 6'h10;
  localparam [5:0] ST_SKIP = 6'h20;

  // ----------------------------------------
  // Pin synchronisation and edges
  // ----------------------------------------
  wire [3:0] pin_s;
  wire cs_n_s;
  wire sclk_s;
  wire si_s;
  wire wp_n_s;
  reg sclk_d_r;
  reg cs_n_d_r;
  wire sclk_rise;
  wire sclk_fall;
  wire cs_fall;
  wire cs_rise;

  fsru_sync #(
    .W(4),
    .RST_VAL(`FSRU_PIN_RST)
  ) u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .d_i({cs_n_i, sclk_i, si_i, wp_n_i}),
    .q_o(pin_s)
  );

  assign cs_n_s = pin_s[3];
  assign sclk_s = pin_s[2];
  assign si_s = pin_s[1];
  assign wp_n_s = pin_s[0];

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sclk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
    end
    else
    begin
      sclk_d_r <= sclk_s;
      cs_n_d_r <= cs_n_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_r & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_d_r & ~cs_n_s;
  assign cs_fall = ~cs_n_s & cs_n_d_r;
  assign cs_rise = cs_n_s & ~cs_n_d_r;

  // ----------------------------------------
  // Serial input bytes
  // ----------------------------------------
  wire [7:0] rx_byte;
  wire rx_done;
  wire [2:0] rx_bit_cnt;

  fsru_shift_in u_rx (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .clr_i(cs_n_s),
    .shift_i(sclk_rise),
    .bit_i(si_s),
    .byte_o(rx_byte),
    .done_o(rx_done),
    .bit_cnt_o(rx_bit_cnt)
  );

  // ----------------------------------------
  // Status state
  // ----------------------------------------
  reg lock_r;
  reg bp0_r;
  reg err_r;
  reg wel_r;
  reg soft_reset_enable_r;
  reg [5:0] st_r;
  reg got_r;
  reg [7:0] wdata_r;
  wire wp_on;
  wire busy;
  wire [7:0] stat1;
  wire [7:0] stat2;
  wire [15:0] live;
  wire wsr_end;
  wire wsr_ok;
  wire rst_take;

  assign wp_on = ~wp_n_s;
  assign busy = op_busy_i;

  assign stat1 = {lock_r, 1'b0, err_r, wp_n_s, 1'b0, bp0_r, wel_r, busy};
  assign stat2 = {3'h0, soft_reset_enable_r, 3'h0, busy};
  assign live = {stat1, stat2};

  // Write data only counts when a whole byte came and deselect is aligned
  assign wsr_end = cs_rise & ((st_r == ST_WSR1) | (st_r == ST_WSR2));
  assign wsr_ok = got_r & (rx_bit_cnt == `FSRU_BIT_FIRST) & wel_r;
  assign rst_take = soft_rst_req_i & soft_reset_enable_r;

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      st_r <= ST_IDLE;
      got_r <= 1'b0;
      wdata_r <= 8'h00;
    end
    else
    begin
      if (cs_n_s)
      begin
        got_r <= 1'b0;
      end
      // Only the first data byte counts; extra bytes are ignored
      else if (rx_done && !got_r && (st_r == ST_WSR1 || st_r == ST_WSR2))
      begin
        wdata_r <= rx_byte;
        got_r <= 1'b1;
      end
      case (st_r)
        ST_IDLE:
        begin
          if (cs_fall)
          begin
            st_r <= ST_CMD;
          end
        end
        ST_CMD:
        begin
          if (cs_n_s)
          begin
            st_r <= ST_IDLE;
          end
          else if (rx_done)
          begin
            case (rx_byte)
              `FSRU_OP_RD_STATUS: st_r <= ST_READ;
              `FSRU_OP_WR_STATUS1: st_r <= ST_WSR1;
              `FSRU_OP_WR_STATUS2: st_r <= ST_WSR2;
              default: st_r <= ST_SKIP;
            endcase
          end
        end
        ST_READ, ST_WSR1, ST_WSR2, ST_SKIP:
        begin
          if (cs_n_s)
          begin
            st_r <= ST_IDLE;
          end
        end
        default:
        begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Status read-out
  // ----------------------------------------
  reg [3:0] seq_r;
  reg [15:0] snap_r;

  always @(posedge clk_i)
  begin
    if (srst_i || cs_n_s)
    begin
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
      seq_r <= `FSRU_SEQ_FIRST;
      snap_r <= 16'h0000;
    end
    else if (st_r == ST_CMD && rx_done && rx_byte == `FSRU_OP_RD_STATUS)
    begin
      so_oe_o <= 1'b1;
      seq_r <= `FSRU_SEQ_FIRST;
    end
    else if (st_r == ST_READ && sclk_fall)
    begin
      seq_r <= seq_r + 4'h1;
      if (seq_r == `FSRU_SEQ_FIRST)
      begin
        snap_r <= live;
        so_o <= live[`FSRU_SEQ_TOP];
      end
      else
      begin
        so_o <= snap_r[`FSRU_SEQ_TOP - seq_r];
      end
    end
  end

  // ----------------------------------------
  // Status bits
  // ----------------------------------------
  // no read side effects: read path above writes none of these
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      lock_r <= `FSRU_RST_LOCK;
      bp0_r <= `FSRU_RST_BP0;
      err_r <= `FSRU_RST_ERR;
      wel_r <= `FSRU_RST_WEL;
      soft_reset_enable_r <= `FSRU_RST_SOFT_RESET_ENABLE;
      soft_reset_o <= 1'b0;
    end
    else
    begin
      soft_reset_o <= rst_take;
      if (op_done_i)
      begin
        err_r <= op_fail_i;
      end
      if (wsr_end && wsr_ok && st_r == ST_WSR1)
      begin
        if (!(wp_on && lock_r && !wdata_r[`FSRU_B1_LOCK]))
        begin
          lock_r <= wdata_r[`FSRU_B1_LOCK];
          if (!(wp_on && lock_r))
          begin
            bp0_r <= wdata_r[`FSRU_B1_BP0];
          end
        end
      end
      if (wsr_end && wsr_ok && st_r == ST_WSR2)
      begin
        soft_reset_enable_r <= wdata_r[`FSRU_B2_SOFT_RESET_ENABLE];
      end
      if (wel_set_i)
      begin
        wel_r <= 1'b1;
      end
      else if (wsr_end || wel_clr_i || rst_take)
      begin
        wel_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Protection outputs
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      protect_lock_o <= `FSRU_RST_LOCK;
      array_protect_o <= `FSRU_RST_BP0;
      write_enable_latch_o <= `FSRU_RST_WEL;
      prog_permit_o <= 1'b0;
    end
    else
    begin
      protect_lock_o <= lock_r;
      array_protect_o <= bp0_r;
      write_enable_latch_o <= wel_r;
      prog_permit_o <= wel_r & ~bp0_r;
    end
  end

endmodule

`default_nettype wire

//--- verilog/fsru_map.vh
// Purpose: Constants for the flash status register unit
// Assumes: Included by bare name from the design files
// Notes: Definitions only
`ifndef FSRU_MAP_VH
`define FSRU_MAP_VH

// ----------------------------------------
// Serial opcodes
// ----------------------------------------
`define FSRU_OP_RD_STATUS 8'h05
`define FSRU_OP_WR_STATUS1 8'h01
`define FSRU_OP_WR_STATUS2 8'h31

// ----------------------------------------
// Status byte one fields
// ----------------------------------------
`define FSRU_B1_LOCK 7
`define FSRU_B1_ERR 5
`define FSRU_B1_WPP 4
`define FSRU_B1_BP0 2
`define FSRU_B1_WEL 1
`define FSRU_B_BUSY 0

// ----------------------------------------
// Status byte two fields
// ----------------------------------------
`define FSRU_B2_SOFT_RESET_ENABLE 4

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define FSRU_RST_LOCK 1'b0
`define FSRU_RST_BP0 1'b0
`define FSRU_RST_ERR 1'b0
`define FSRU_RST_WEL 1'b0
`define FSRU_RST_SOFT_RESET_ENABLE 1'b0
`define FSRU_PIN_RST 4'h9
`define FSRU_BIT_LAST 3'h7
`define FSRU_BIT_FIRST 3'h0
`define FSRU_SEQ_FIRST 4'h0
`define FSRU_SEQ_TOP 4'hF

`endif

//--- verilog/fsru_sync.v
// Purpose: Two-flop synchroniser for asynchronous pins
// Assumes: Inputs are levels from outside the clk_i domain
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module fsru_sync #(
  parameter W = 4,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // Pins in, synchronised out
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);

  reg [W-1:0] meta_r;

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      meta_r <= RST_VAL;
      q_o <= RST_VAL;
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule

`default_nettype wire

//--- verilog/fsru_shift_in.v
// Purpose: Serial input byte assembler, MSB first
// Assumes: shift_i is a one-cycle pulse per serial clock rise
// Notes: done_o pulses one cycle after the eighth bit
`timescale 1ns/1ps
`default_nettype none
`include "fsru_map.vh"

module fsru_shift_in (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // Serial side
  input wire clr_i,
  input wire shift_i,
  input wire bit_i,
  // Byte side
  output reg [7:0] byte_o,
  output reg done_o,
  output reg [2:0] bit_cnt_o
);

  reg [6:0] sh_r;

  always @(posedge clk_i)
  begin
    if (srst_i || clr_i)
    begin
      sh_r <= 7'h00;
      byte_o <= 8'h00;
      done_o <= 1'b0;
      bit_cnt_o <= `FSRU_BIT_FIRST;
    end
    else
    begin
      done_o <= 1'b0;
      if (shift_i)
      begin
        sh_r <= {sh_r[5:0], bit_i};
        bit_cnt_o <= bit_cnt_o + 3'h1;
        if (bit_cnt_o == `FSRU_BIT_LAST)
        begin
          byte_o <= {sh_r, bit_i};
          done_o <= 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

//--- sim/fsru_top_properties.sv
// Purpose: Port checks for the status unit
// Assumes: Serial clock at least 8x slower than clk_i
// Notes: Bound to fsru_top at the foot
`timescale 1ns/1ps
`default_nettype none
module fsru_top_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Inputs watched
  input wire logic cs_n_i,
  input wire logic wp_n_i,
  input wire logic wel_clr_i,
  input wire logic wel_set_i,
  input wire logic soft_rst_req_i,
  // Outputs watched
  input wire logic so_o,
  input wire logic so_oe_o,
  input wire logic protect_lock_o,
  input wire logic array_protect_o,
  input wire logic write_enable_latch_o,
  input wire logic prog_permit_o,
  input wire logic soft_reset_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  // Pin held asserted long enough to pass the synchroniser
  sequence s_wp_lock;
    !wp_n_i [*8] ##1 protect_lock_o;
  endsequence
  property p_oe_off;
    cs_n_i [*6] |-> !so_oe_o;
  endproperty
  property p_oe_quiet;
    !so_oe_o |-> !so_o;
  endproperty
  property p_oe_cs;
    $rose(so_oe_o) |-> !cs_n_i && $past(cs_n_i, 8) == 1'h0;
  endproperty
  // Both directions, so a permit stuck low is caught as well
  property p_permit;
    prog_permit_o == (write_enable_latch_o && !array_protect_o);
  endproperty
  property p_srst_src;
    soft_reset_o |-> $past(soft_rst_req_i) || $past(soft_rst_req_i, 2);
  endproperty
  property p_srst_one;
    soft_reset_o |=> !soft_reset_o;
  endproperty
  // A set in the same cycle wins over the clear
  property p_wel_clr;
    wel_clr_i && !wel_set_i |-> ##2 !write_enable_latch_o;
  endproperty
  property p_lock_hold;
    s_wp_lock |=> protect_lock_o;
  endproperty
  property p_prot_frz;
    s_wp_lock |=> $stable(array_protect_o);
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("so driven after deselect");
  a_oe_quiet: assert property (p_oe_quiet) else $error("so not low when off");
  a_oe_cs: assert property (p_oe_cs) else $error("so enabled outside a frame");
  a_permit: assert property (p_permit) else $error("permit without wel");
  a_srst_src: assert property (p_srst_src) else $error("soft reset unasked");
  a_srst_one: assert property (p_srst_one) else $error("soft reset too long");
  a_wel_clr: assert property (p_wel_clr) else $error("wel not cleared");
  a_lock_hold: assert property (p_lock_hold) else $error("lock fell with wp");
  a_prot_frz: assert property (p_prot_frz) else $error("protect moved locked");
  c_srst: cover property (soft_reset_o);
  c_read: cover property ($rose(so_oe_o));
  c_wel: cover property ($fell(write_enable_latch_o));
endmodule
bind fsru_top fsru_top_properties u_props (
  .clk_i(clk_i),
  .srst_i(srst_i),
  .cs_n_i(cs_n_i),
  .wp_n_i(wp_n_i),
  .wel_clr_i(wel_clr_i),
  .wel_set_i(wel_set_i),
  .soft_rst_req_i(soft_rst_req_i),
  .so_o(so_o),
  .so_oe_o(so_oe_o),
  .protect_lock_o(protect_lock_o),
  .array_protect_o(array_protect_o),
  .write_enable_latch_o(write_enable_latch_o),
  .prog_permit_o(prog_permit_o),
  .soft_reset_o(soft_reset_o)
);
`default_nettype wire

//--- sim/fsru_spi_host.sv
// Purpose: Mode 0 serial host for the status unit
// Assumes: Called at a falling clk_i edge
// Notes: Serial clock idles low between frames
`timescale 1ns/1ps
`default_nettype none
module fsru_spi_host (
  // Clock
  input wire logic clk_i,
  // Serial link
  input wire logic so_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic si_o
);
  initial
  begin
    cs_n_o = 1'h1;
    sclk_o = 1'h0;
    si_o = 1'h0;
  end
  task automatic tick();
    sclk_o = 1'h0;
    repeat (4) @(negedge clk_i);
    sclk_o = 1'h1;
    repeat (4) @(negedge clk_i);
  endtask
  task automatic xfer(input logic [7:0] op, input int no, input logic [7:0] d,
                      input int nd, input int nr, output logic [31:0] r);
    r = 32'h0;
    cs_n_o = 1'h0;
    for (int i = 0; i < no + nd; i++)
    begin
      si_o = (i < no) ? op[7 - i] : d[7 - (i - no)];
      tick();
    end
    for (int i = 0; i < nr; i++)
    begin
      si_o = ~si_o;
      tick();
      r = {r[30:0], so_i};
    end
    sclk_o = 1'h0;
    si_o = ~si_o;
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'h1;
    repeat (8) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

//--- sim/fsru_top_tb.sv
// Purpose: Self-checking bench for fsru_top
// Assumes: Serial clock 80 ns from the host model
// Notes: Expected status comes from a bit model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module fsru_top_tb;
  logic clk_i = 1'h0, srst_i = 1'h1, wp_n_i = 1'h1, op_busy_i = 1'h0, op_done_i = 1'h0;
  logic op_fail_i = 1'h0, wel_set_i = 1'h0, wel_clr_i = 1'h0, soft_rst_req_i = 1'h0;
  logic lock = 1'h0, prot = 1'h0, err = 1'h0, write_enable_latch = 1'h0, soft_reset_enable = 1'h0;
  logic [3:0] wp, k, no, nd;
  logic [7:0] op, d;
  logic [31:0] r, e;
  logic [31:0] tbl [11] = '{32'h10801848, 32'h11801048, 32'h11801805, 32'h11401000,
    32'h108A5000, 32'h10801848, 32'h01801808, 32'h01801008, 32'h11801008,
    32'h01801848, 32'h11831108};
  wire cs_n, sclk, si, so_o, so_oe_o, so_w, lock_o, prot_o, wel_o, permit_o, srst_o;
  int miscompares = 0, cmp_count = 0, cyc = 0;
  assign so_w = so_oe_o ? so_o : 1'bz;
  always #5 clk_i = ~clk_i;
  fsru_top dut (.clk_i(clk_i), .srst_i(srst_i), .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si),
    .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o), .op_busy_i(op_busy_i),
    .op_done_i(op_done_i), .op_fail_i(op_fail_i), .wel_set_i(wel_set_i),
    .wel_clr_i(wel_clr_i), .soft_rst_req_i(soft_rst_req_i), .protect_lock_o(lock_o),
    .array_protect_o(prot_o), .write_enable_latch_o(wel_o), .prog_permit_o(permit_o),
    .soft_reset_o(srst_o));
  fsru_spi_host host (.clk_i(clk_i), .so_i(so_w), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si));
  function automatic logic [15:0] st();
    return {lock, 1'h0, err, wp_n_i, 1'h0, prot, write_enable_latch, op_busy_i, 3'h0, soft_reset_enable, 3'h0, op_busy_i};
  endfunction
  task automatic stop_test();
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk_out();
    repeat (8) @(negedge clk_i);
    `CHK({lock_o, prot_o, wel_o, permit_o}, {lock, prot, write_enable_latch, write_enable_latch & ~prot})
  endtask
  task automatic rd(input int n);
    e = {st(), st()} >> (32 - n);
    host.xfer(8'h05, 8, 8'h00, 0, n, r);
    `CHK(r, e)
    `CHK(so_oe_o, 1'h0)
  endtask
  task automatic wr();
    host.xfer(op, no, d, nd, 0, r);
    // Status writes need wel and a whole data byte
    if (write_enable_latch && nd == 4'h8 && op == 8'h31)
      soft_reset_enable = d[4];
    if (write_enable_latch && nd == 4'h8 && op == 8'h01 && (wp_n_i || !lock))
    begin
      prot = d[2];
      lock = d[7];
    end
    if (no == 4'h8 && (op == 8'h01 || op == 8'h31))
      write_enable_latch = 1'h0;
    chk_out();
  endtask
  task automatic we();
    wel_set_i = 1'h1;
    @(negedge clk_i);
    wel_set_i = 1'h0;
    write_enable_latch = 1'h1;
  endtask
  task automatic sr();
    logic s;
    soft_rst_req_i = 1'h1;
    @(negedge clk_i);
    s = srst_o;
    soft_rst_req_i = 1'h0;
    @(negedge clk_i);
    `CHK(s | srst_o, soft_reset_enable)
    if (soft_reset_enable)
      write_enable_latch = 1'h0;
  endtask
  task automatic dn(input logic f);
    op_fail_i = f;
    op_done_i = 1'h1;
    @(negedge clk_i);
    op_done_i = 1'h0;
    err = f;
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      miscompares++;
      stop_test();
    end
  end
  initial
  begin
    void'($urandom(32'h2DF1));
    repeat (10) @(negedge clk_i);
    srst_i = 1'h0;
    repeat (3) @(negedge clk_i);
    chk_out();
    rd(32);
    sr();
    wp_n_i = 1'h0;
    rd(32);
    foreach (tbl[i])
    begin
      {wp, k, no, op, d, nd} = tbl[i];
      wp_n_i = wp[0];
      if (k[0])
        we();
      // Don't-care data bits are randomised
      d = d | (8'($urandom) & ((op == 8'h31) ? 8'hEF : 8'h7B));
      wr();
    end
    rd(32);
    we();
    sr();
    chk_out();
    e = {st(), 16'h0};
    fork
      host.xfer(8'h05, 8, 8'h00, 0, 32, r);
      begin
        repeat (100) @(negedge clk_i);
        op_busy_i = 1'h1;
      end
    join
    e[15:0] = st();
    `CHK(r, e)
    dn(1'h1);
    rd(16);
    op_busy_i = 1'h0;
    // Operation ends with no done pulse: an abort keeps the old error
    rd(16);
    dn(1'h0);
    rd(32);
    we();
    wel_clr_i = 1'h1;
    @(negedge clk_i);
    wel_clr_i = 1'h0;
    write_enable_latch = 1'h0;
    chk_out();
    rd(13);
    rd(32);
    stop_test();
  end
endmodule
`default_nettype wire
